// ===== inc/ext_bus_pkg.sv
/*
  Constants for the external bus pin controller: register offsets, field
  positions, reset values, state encoding and the bus-cycle divider.
  Assumes a single system clock; the CPU bus rate is an enable from it.
*/
package ext_bus_pkg;
  localparam int unsigned CPU_CLK_DIV = 2;
  localparam int unsigned DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CPU_CLK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CPU_CLK_DIV / 2);
  localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;

  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] STRAP_ZERO = 2'h0;

  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 16;
  localparam logic [REG_AW-1:0] SYSTEM_CONFIG_OFS = 8'h00;
  localparam logic [REG_AW-1:0] SEG_DIR_OFS = 8'h04;
  localparam logic [REG_AW-1:0] SEG_DATA_OFS = 8'h08;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h0c;

  localparam int unsigned CFG_WRITE_STROBE_CONFIG_BIT_BIT = 0;
  localparam int unsigned CFG_MUX_BIT = 1;
  localparam int unsigned CFG_BUS16_BIT = 2;
  localparam int unsigned CFG_READY_EN_BIT = 3;
  localparam int unsigned CFG_SYSTEM_CLOCK_OUTPUT_EN_BIT = 4;
  localparam int unsigned CFG_SEG_ADDR_BIT = 5;
  localparam int unsigned CFG_W = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h06;

  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_BOOT_EXT_BIT = 1;
  localparam int unsigned ST_READY_BIT = 2;
  localparam int unsigned ST_DEMUX_SEEN_BIT = 3;
  localparam int unsigned ST_SEG_PIN_LSB = 8;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEG_W = 8;
  localparam int unsigned SEG_LSB = 16;
  localparam int unsigned BYTE_W = 8;

  localparam logic [SEG_W-1:0] SEG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_STROBE = 2'b11,
    ST_FINISH = 2'b10
  } bus_state_e;
endpackage

// ===== hdl/pin_sync.sv
/*
  Two-flop synchroniser bank for pins that arrive from outside the clock.
  Assumes every bit is an independent level; no bit pairing is kept.
*/
module pin_sync
  import ext_bus_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // asynchronous pins
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] stage_r [SYNC_STAGES];

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      stage_r[0] <= '0;
    end else begin
      stage_r[0] <= pin_in;
    end
  end

  genvar g;
  generate
    for (g = 1; g < SYNC_STAGES; g++) begin : g_stage
      always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
          stage_r[g] <= '0;
        end else begin
          stage_r[g] <= stage_r[g-1];
        end
      end
    end
  endgenerate

  assign sync_out = stage_r[SYNC_STAGES-1];
endmodule

// ===== hdl/ext_bus_pins.sv
/*
  External bus pin controller: sequences one external access at a time on
  the read, write and high-byte strobes, address latch strobe, shared
  address/data port, demultiplexed address port and segment port.
  Assumes the CPU side holds request fields only in the cycle of req_in and
  that the board keeps the access select pin at its strap level.
*/
// Operation
// - read strobe asserted for every external fetch or data read
// - full-write mode: write strobe on every data write
// - low-byte mode: strobe on low-byte writes at 16 bits, all writes at 8
// - config bit in system config register picks the write strobe mode
// - ready enabled and ready pin high keeps inserting wait states
// - multiplexed modes provide address latch strobe
// - access select low at reset boots external, high boots internal
// - segment port drives address bits 16 to 23, bit 0 lowest
// - one pin serves as high-byte enable or high-byte write strobe
// - segment port bits have own direction; input bits float the driver
// - system clock output runs at the CPU clock rate
// - data port carries address and data muxed, data only demuxed
// - address port drives address demuxed and after demux-to-mux switch
module ext_bus_pins
  import ext_bus_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic [REG_AW-1:0] reg_addr_in, // register byte address
  input wire logic [REG_DW-1:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  output logic [REG_DW-1:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic req_in, // access request pulse
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic req_fetch_in, // instruction fetch
  input wire logic [ADDR_W-1:0] req_addr_in, // access address
  input wire logic [DATA_W-1:0] req_wdata_in, // write data
  input wire logic [1:0] req_byte_en_in, // byte lanes, bit 1 high byte
  output logic busy_out, // access in progress
  output logic done_out, // access finished pulse
  output logic [DATA_W-1:0] rdata_out, // read data at done
  output logic boot_external_out, // start execution externally
  output logic rd_strobe_n_out, // read strobe, active low
  output logic wr_strobe_n_out, // write or low-byte write strobe, active low
  output logic high_byte_n_out, // high-byte enable or write strobe, low
  output logic ale_out, // address latch strobe, active high
  input wire logic ready_n_in, // ready pin, high inserts waits
  input wire logic access_select_in, // access select pin
  output logic system_clock_output, // system clock output
  input wire logic [DATA_W-1:0] address_data_port_in, // shared port pins
  output logic [DATA_W-1:0] address_data_port_out, // shared port drive
  output logic [DATA_W-1:0] address_data_port_oe_out, // shared port enable
  output logic [DATA_W-1:0] demux_address_port_out, // address port drive
  output logic [DATA_W-1:0] demux_address_port_oe_out, // address port enable
  input wire logic [SEG_W-1:0] segment_port_in, // segment port pins
  output logic [SEG_W-1:0] segment_port_out, // segment port drive
  output logic [SEG_W-1:0] segment_port_oe_out // segment port enable
);
  function automatic logic reg_hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  logic [DATA_W-1:0] ad_sync;
  logic [SEG_W-1:0] seg_sync;
  logic ready_sync;
  logic select_sync;

  pin_sync #(.WIDTH(DATA_W + SEG_W + 2)) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in({address_data_port_in, segment_port_in, ready_n_in, access_select_in}),
    .sync_out({ad_sync, seg_sync, ready_sync, select_sync})
  );

  logic [CFG_W-1:0] system_config_register_r;
  logic [SEG_W-1:0] seg_dir_r;
  logic [SEG_W-1:0] seg_data_r;
  logic wr_cfg;
  logic cfg_mux;
  logic cfg_bus16;
  logic cfg_ready_en;

  assign wr_cfg = system_config_register_r[CFG_WRITE_STROBE_CONFIG_BIT_BIT];
  assign cfg_mux = system_config_register_r[CFG_MUX_BIT];
  assign cfg_bus16 = system_config_register_r[CFG_BUS16_BIT];
  assign cfg_ready_en = system_config_register_r[CFG_READY_EN_BIT];

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      system_config_register_r <= CFG_RESET;
    end else if (reg_wr_in && reg_hit(reg_addr_in, SYSTEM_CONFIG_OFS)) begin
      system_config_register_r <= reg_wdata_in[CFG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      seg_dir_r <= SEG_RESET;
      seg_data_r <= SEG_RESET;
    end else if (reg_wr_in) begin
      if (reg_hit(reg_addr_in, SEG_DIR_OFS)) begin
        seg_dir_r <= reg_wdata_in[SEG_W-1:0];
      end
      if (reg_hit(reg_addr_in, SEG_DATA_OFS)) begin
        seg_data_r <= reg_wdata_in[SEG_W-1:0];
      end
    end
  end

  // cpu bus rate enable and clock output
  logic [DIV_W-1:0] div_cnt_r;
  logic tick;
  logic clk_out_r;

  assign tick = (div_cnt_r == DIV_LAST);

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      div_cnt_r <= DIV_ZERO;
    end else if (tick) begin
      div_cnt_r <= DIV_ZERO;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      clk_out_r <= 1'b0;
    end else begin
      // high over the first half of each bus period
      clk_out_r <= system_config_register_r[CFG_SYSTEM_CLOCK_OUTPUT_EN_BIT] &&
                   (tick || (div_cnt_r < DIV_HALF - 2'h1));
    end
  end
  assign system_clock_output = clk_out_r;

  // strap capture once the synchroniser has settled after release
  logic [1:0] strap_cnt_r;
  logic boot_ext_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      strap_cnt_r <= STRAP_WAIT;
      boot_ext_r <= 1'b1;
    end else if (strap_cnt_r != STRAP_ZERO) begin
      strap_cnt_r <= strap_cnt_r - 2'h1;
      if (strap_cnt_r == 2'h1) begin
        boot_ext_r <= ~select_sync;
      end
    end
  end
  assign boot_external_out = boot_ext_r;

  // request capture
  logic pend_r;
  logic pend_write_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [DATA_W-1:0] pend_wdata_r;
  logic [1:0] pend_be_r;
  bus_state_e state_r;
  logic busy_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pend_r <= 1'b0;
      pend_write_r <= 1'b0;
      pend_addr_r <= '0;
      pend_wdata_r <= DATA_ZERO;
      pend_be_r <= 2'h0;
    end else if (req_in && !busy_r) begin
      pend_r <= 1'b1;
      pend_write_r <= req_write_in && !req_fetch_in;
      pend_addr_r <= req_addr_in;
      pend_wdata_r <= req_wdata_in;
      pend_be_r <= req_byte_en_in;
    end else if (tick && state_r == ST_IDLE) begin
      pend_r <= 1'b0;
    end
  end

  logic wait_req;
  assign wait_req = cfg_ready_en && ready_sync;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else if (tick) begin
      case (state_r)
        ST_IDLE: begin
          if (pend_r) begin
            state_r <= cfg_mux ? ST_LATCH : ST_STROBE;
          end
        end
        ST_LATCH: state_r <= ST_STROBE;
        ST_STROBE: begin
          if (!wait_req) begin
            state_r <= ST_FINISH;
          end
        end
        ST_FINISH: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      busy_r <= 1'b0;
    end else if (req_in && !busy_r) begin
      busy_r <= 1'b1;
    end else if (tick && state_r == ST_FINISH) begin
      busy_r <= 1'b0;
    end
  end
  assign busy_out = busy_r;

  // strobe decode
  logic lo_wr_en;
  logic hi_wr_en;
  logic hi_enable;

  always_comb begin
    if (!wr_cfg) begin
      lo_wr_en = pend_write_r;
    end else begin
      lo_wr_en = pend_write_r && (!cfg_bus16 || pend_be_r[0]);
    end
    hi_wr_en = pend_write_r && cfg_bus16 && pend_be_r[1];
    hi_enable = cfg_bus16 && pend_be_r[1];
  end

  logic enter_strobe;
  logic leave_strobe;
  assign enter_strobe = tick && ((state_r == ST_IDLE && pend_r && !cfg_mux) || state_r == ST_LATCH);
  assign leave_strobe = tick && state_r == ST_STROBE && !wait_req;

  logic rd_n_r;
  logic wr_n_r;
  logic hb_n_r;
  logic ale_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end else if (enter_strobe) begin
      rd_n_r <= pend_write_r;
      wr_n_r <= ~lo_wr_en;
    end else if (leave_strobe) begin
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      hb_n_r <= 1'b1;
    end else if (wr_cfg) begin
      // high-byte write strobe timed with the write strobe
      if (enter_strobe) begin
        hb_n_r <= ~hi_wr_en;
      end else if (leave_strobe) begin
        hb_n_r <= 1'b1;
      end
    end else if (tick && state_r == ST_IDLE && pend_r) begin
      hb_n_r <= ~hi_enable;
    end else if (leave_strobe) begin
      hb_n_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ale_r <= 1'b0;
    end else begin
      ale_r <= tick && state_r == ST_IDLE && pend_r && cfg_mux;
    end
  end

  assign rd_strobe_n_out = rd_n_r;
  assign wr_strobe_n_out = wr_n_r;
  assign high_byte_n_out = hb_n_r;
  assign ale_out = ale_r;

  // shared address/data port
  logic [DATA_W-1:0] ad_r;
  logic [DATA_W-1:0] ad_oe_r;
  logic [DATA_W-1:0] hi_lane_oe;

  assign hi_lane_oe = {{BYTE_W{1'b1}}, {BYTE_W{1'b0}}};

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ad_r <= DATA_ZERO;
      ad_oe_r <= DATA_ZERO;
    end else if (tick) begin
      if (state_r == ST_IDLE && pend_r && cfg_mux) begin
        ad_r <= pend_addr_r[DATA_W-1:0];
        ad_oe_r <= ~DATA_ZERO;
      end else if (enter_strobe) begin
        if (pend_write_r) begin
          ad_r <= cfg_bus16 ? pend_wdata_r : {pend_addr_r[DATA_W-1:BYTE_W], pend_wdata_r[BYTE_W-1:0]};
          ad_oe_r <= (cfg_bus16 || cfg_mux) ? ~DATA_ZERO : ~hi_lane_oe;
        end else begin
          // 8-bit muxed keeps the high address byte on the upper lane
          ad_oe_r <= (!cfg_bus16 && cfg_mux) ? hi_lane_oe : DATA_ZERO;
        end
      end else if (state_r == ST_FINISH) begin
        ad_oe_r <= DATA_ZERO;
      end
    end
  end
  assign address_data_port_out = ad_r;
  assign address_data_port_oe_out = ad_oe_r;

  // demultiplexed address port
  logic demux_seen_r;
  logic [DATA_W-1:0] a_port_r;
  logic [DATA_W-1:0] a_port_oe_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      demux_seen_r <= 1'b0;
    end else if (!cfg_mux) begin
      demux_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      a_port_r <= DATA_ZERO;
      a_port_oe_r <= DATA_ZERO;
    end else begin
      a_port_oe_r <= (!cfg_mux || demux_seen_r) ? ~DATA_ZERO : DATA_ZERO;
      if (tick && state_r == ST_IDLE && pend_r) begin
        a_port_r <= pend_addr_r[DATA_W-1:0];
      end
    end
  end
  assign demux_address_port_out = a_port_r;
  assign demux_address_port_oe_out = a_port_oe_r;

  // segment port
  logic [SEG_W-1:0] seg_addr_r;
  logic [SEG_W-1:0] seg_out_r;
  logic [SEG_W-1:0] seg_oe_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      seg_addr_r <= SEG_RESET;
    end else if (tick && state_r == ST_IDLE && pend_r) begin
      seg_addr_r <= pend_addr_r[SEG_LSB +: SEG_W];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      seg_out_r <= SEG_RESET;
      seg_oe_r <= SEG_RESET;
    end else begin
      seg_oe_r <= seg_dir_r;
      seg_out_r <= system_config_register_r[CFG_SEG_ADDR_BIT] ? seg_addr_r : seg_data_r;
    end
  end
  assign segment_port_out = seg_out_r;
  assign segment_port_oe_out = seg_oe_r;

  // read data and completion
  logic done_r;
  logic [DATA_W-1:0] rdata_r;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      done_r <= 1'b0;
      rdata_r <= DATA_ZERO;
    end else begin
      done_r <= tick && state_r == ST_FINISH;
      if (tick && state_r == ST_FINISH && !pend_write_r) begin
        rdata_r <= cfg_bus16 ? ad_sync : {{BYTE_W{1'b0}}, ad_sync[BYTE_W-1:0]};
      end
    end
  end
  assign done_out = done_r;
  assign rdata_out = rdata_r;

  // register read port
  logic [REG_DW-1:0] rdata_nxt;
  logic [REG_DW-1:0] reg_rdata_r;

  always_comb begin
    rdata_nxt = '0;
    if (reg_hit(reg_addr_in, SYSTEM_CONFIG_OFS)) begin
      rdata_nxt[CFG_W-1:0] = system_config_register_r;
    end else if (reg_hit(reg_addr_in, SEG_DIR_OFS)) begin
      rdata_nxt[SEG_W-1:0] = seg_dir_r;
    end else if (reg_hit(reg_addr_in, SEG_DATA_OFS)) begin
      rdata_nxt[SEG_W-1:0] = seg_data_r;
    end else if (reg_hit(reg_addr_in, STATUS_OFS)) begin
      rdata_nxt[ST_BUSY_BIT] = busy_r;
      rdata_nxt[ST_BOOT_EXT_BIT] = boot_ext_r;
      rdata_nxt[ST_READY_BIT] = ready_sync;
      rdata_nxt[ST_DEMUX_SEEN_BIT] = demux_seen_r;
      rdata_nxt[ST_SEG_PIN_LSB +: SEG_W] = seg_sync;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_r <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= '0;
    end
  end
  assign reg_rdata_out = reg_rdata_r;
endmodule

// ===== dv/ext_bus_sva.sv
/*
  Port checker for the external bus pin controller.
  Assumes it is bound into ext_bus_pins and config changes only while idle.
*/
module ext_bus_sva
  import ext_bus_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic resetn_in, // reset
  input wire logic [REG_AW-1:0] reg_addr_in, // reg address
  input wire logic [REG_DW-1:0] reg_wdata_in, // reg data
  input wire logic reg_wr_in, // reg write
  input wire logic req_in, // request
  input wire logic req_write_in, // write
  input wire logic req_fetch_in, // fetch
  input wire logic [1:0] req_byte_en_in, // lanes
  input wire logic busy_out, // busy
  input wire logic rd_strobe_n_out, // read strobe
  input wire logic wr_strobe_n_out, // write strobe
  input wire logic high_byte_n_out, // high byte
  input wire logic ale_out, // latch strobe
  input wire logic ready_n_in, // ready pin
  input wire logic access_select_in, // strap
  input wire logic boot_external_out, // boot
  input wire logic system_clock_output, // clock out
  input wire logic [DATA_W-1:0] address_data_port_out, // shared port
  input wire logic [DATA_W-1:0] demux_address_port_oe_out, // address enable
  input wire logic [SEG_W-1:0] segment_port_oe_out // segment enable
);
  logic [CFG_W-1:0] cfg_r;
  logic seen_r;
  logic wrq;
  logic rdq;
  logic lowm;
  logic strb;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      cfg_r <= CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == SYSTEM_CONFIG_OFS) begin
      cfg_r <= reg_wdata_in[CFG_W-1:0];
    end
  end
  always_ff @(posedge sys_clk_in) begin
    seen_r <= resetn_in && (seen_r || !cfg_r[CFG_MUX_BIT]);
  end
  assign wrq = req_in && !busy_out && req_write_in && !req_fetch_in;
  assign rdq = req_in && !busy_out && (!req_write_in || req_fetch_in);
  assign lowm = cfg_r[CFG_WRITE_STROBE_CONFIG_BIT_BIT] && cfg_r[CFG_BUS16_BIT];
  assign strb = !(rd_strobe_n_out && wr_strobe_n_out);
  AST_READ_STROBE: assert property (rdq |-> ##[2:8] !rd_strobe_n_out)
    else $error("read access without read strobe");
  AST_FULL_WRITE: assert property (wrq && !cfg_r[CFG_WRITE_STROBE_CONFIG_BIT_BIT] |-> ##[2:8] !wr_strobe_n_out)
    else $error("full write mode missed write strobe");
  AST_LOW_SKIP: assert property (wrq && lowm && !req_byte_en_in[0] |-> wr_strobe_n_out [*8])
    else $error("low strobe on high-only write");
  AST_LOW_HIT: assert property (wrq && cfg_r[CFG_WRITE_STROBE_CONFIG_BIT_BIT] && (req_byte_en_in[0] || !cfg_r[CFG_BUS16_BIT])
    |-> ##[2:8] !wr_strobe_n_out)
    else $error("low strobe missing");
  AST_HIGH_WRITE: assert property (wrq && lowm && req_byte_en_in[1] |-> ##[2:8] !high_byte_n_out)
    else $error("high byte strobe missing");
  AST_READY_HOLD: assert property ((cfg_r[CFG_READY_EN_BIT] && ready_n_in) [*4] ##0 strb |=> strb)
    else $error("strobe ended while not ready");
  AST_ALE_FIRST: assert property (cfg_r[CFG_MUX_BIT] && $fell(!strb) |-> $past(ale_out, 2) && !ale_out)
    else $error("strobe without preceding latch pulse");
  AST_ALE_ADDR: assert property ($fell(ale_out) |-> $stable(address_data_port_out))
    else $error("address moved under latch pulse");
  AST_CLK_OUT: assert property ($rose(system_clock_output) |=> !system_clock_output ##1 system_clock_output)
    else $error("clock output period wrong");
  AST_SEG_DIR: assert property (reg_wr_in && reg_addr_in == SEG_DIR_OFS ##1 (!reg_wr_in) [*2]
    |-> segment_port_oe_out == $past(reg_wdata_in[SEG_W-1:0], 2))
    else $error("segment enable differs from direction");
  AST_DEMUX_OE: assert property (seen_r [*3] |-> demux_address_port_oe_out == 16'hffff)
    else $error("address port not driven");
  AST_BOOT: assert property ($stable(access_select_in) [*5] |-> boot_external_out == !access_select_in)
    else $error("boot source wrong");
  COV_WAIT: cover property ((ready_n_in && strb) [*4]);
  COV_LOW: cover property (wrq && lowm);
  COV_DEMUX: cover property (rdq && !cfg_r[CFG_MUX_BIT]);
endmodule

bind ext_bus_pins ext_bus_sva u_sva (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .req_in,
  .req_write_in, .req_fetch_in, .req_byte_en_in, .busy_out, .rd_strobe_n_out, .wr_strobe_n_out, .high_byte_n_out,
  .ale_out, .ready_n_in, .access_select_in, .boot_external_out, .system_clock_output, .address_data_port_out,
  .demux_address_port_oe_out, .segment_port_oe_out);

// ===== dv/bus_memory_model.sv
/*
  Far-side memory for the pin controller, with ready wait states.
  Assumes the bench resolves the shared port from the controller's enable alone.
*/
module bus_memory_model
  import ext_bus_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic mux_in, // multiplexed mode
  input wire logic [3:0] wait_in, // wait cycles
  input wire logic ale_in, // latch strobe
  input wire logic rd_n_in, // read strobe
  input wire logic wr_n_in, // write strobe
  input wire logic [DATA_W-1:0] bus_in, // shared level
  input wire logic [DATA_W-1:0] addr_in, // demux address
  output logic [DATA_W-1:0] drive_out, // shared drive
  output logic ready_n_out // ready pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [256];
  logic [7:0] lat_r = 8'h00;
  logic [3:0] wcnt = 4'h0;
  logic [1:0] hold = 2'h0;
  logic [7:0] a;
  assign a = mux_in ? lat_r : addr_in[7:0];
  initial begin
    drive_out = 16'h5a5a;
    ready_n_out = 1'b0;
  end
  // address taken at the latch pulse fall
  always @(negedge ale_in) lat_r = bus_in[7:0];
  always @(posedge sys_clk_in) begin
    if (!wr_n_in) begin
      mem[a] <= bus_in;
    end
    wcnt <= (rd_n_in && wr_n_in) ? 4'h0 : wcnt + 4'h1;
    // not ready by default when a wait is set, ready once the wait has run
    ready_n_out <= wait_in != 4'h0 && !(!(rd_n_in && wr_n_in) && wcnt >= wait_in);
    if (!rd_n_in) begin
      drive_out <= mem[a];
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      drive_out <= ~drive_out;
    end
  end
endmodule

// ===== dv/tb_top.sv
/*
  Top bench: pin controller, far-side memory and bound checker.
  Assumes a 20 MHz clock and synchronous active-low reset.
*/
module tb_top
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [REG_AW-1:0] reg_addr_in = 8'h00;
  logic [REG_DW-1:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic req_in = 1'b0;
  logic req_write_in = 1'b0;
  logic req_fetch_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = 24'h000000;
  logic [DATA_W-1:0] req_wdata_in = 16'h0000;
  logic [1:0] req_byte_en_in = 2'h3;
  logic access_select_in = 1'b0;
  logic mux_m = 1'b1;
  logic [3:0] wait_m = 4'h0;
  logic [REG_DW-1:0] reg_rdata_out;
  logic [DATA_W-1:0] rdata_out, drv, address_data_port_in, address_data_port_out, address_data_port_oe_out;
  logic [DATA_W-1:0] demux_address_port_out, demux_address_port_oe_out;
  logic [SEG_W-1:0] segment_port_in, segment_port_out, segment_port_oe_out;
  logic busy_out, done_out, boot_external_out, rd_strobe_n_out, wr_strobe_n_out, high_byte_n_out;
  logic ale_out, ready_n_in, system_clock_output;
  logic [15:0] lfsr_r = 16'h27ad;
  logic [15:0] rd_cap, dmx_cap;
  logic [7:0] seg_cap;
  int low_cnt;
  int bad_count = 0;
  int check_count = 0;
  assign address_data_port_in = (address_data_port_oe_out & address_data_port_out) | (~address_data_port_oe_out & drv);
  assign segment_port_in = segment_port_out;
  always #25 sys_clk_in = ~sys_clk_in;
  ext_bus_pins dut (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .req_in, .req_write_in, .req_fetch_in, .req_addr_in, .req_wdata_in, .req_byte_en_in, .busy_out, .done_out,
    .rdata_out, .boot_external_out, .rd_strobe_n_out, .wr_strobe_n_out, .high_byte_n_out, .ale_out, .ready_n_in,
    .access_select_in, .system_clock_output, .address_data_port_in, .address_data_port_out,
    .address_data_port_oe_out, .demux_address_port_out, .demux_address_port_oe_out, .segment_port_in,
    .segment_port_out, .segment_port_oe_out);
  bus_memory_model mem_u (.sys_clk_in(sys_clk_in), .mux_in(mux_m), .wait_in(wait_m), .ale_in(ale_out),
    .rd_n_in(rd_strobe_n_out), .wr_n_in(wr_strobe_n_out), .bus_in(address_data_port_in),
    .addr_in(demux_address_port_out), .drive_out(drv), .ready_n_out(ready_n_in));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    mux_m <= (a == SYSTEM_CONFIG_OFS) ? d[CFG_MUX_BIT] : mux_m;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    d = reg_rdata_out;
    @(posedge sys_clk_in);
  endtask
  task automatic access(input logic w, input logic f, input logic [23:0] a, input logic [15:0] d,
    input logic [1:0] be);
    int n;
    req_in <= 1'b1;
    req_write_in <= w;
    req_fetch_in <= f;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_byte_en_in <= be;
    @(posedge sys_clk_in);
    req_in <= 1'b0;
    low_cnt = 0;
    for (n = 0; n < 60 && done_out !== 1'b1; n++) begin
      @(negedge sys_clk_in);
      if (!(rd_strobe_n_out && wr_strobe_n_out)) begin
        low_cnt++;
        seg_cap = segment_port_out;
        dmx_cap = demux_address_port_out;
      end
    end
    rd_cap = rdata_out;
    chk("done", 24'h1, 24'(done_out));
    @(posedge sys_clk_in);
  endtask
  initial begin
    logic [15:0] v;
    logic [23:0] adr [6];
    logic [15:0] dat [6];
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd(SYSTEM_CONFIG_OFS, v);
    chk("config reset", 24'(CFG_RESET), 24'(v));
    reg_rd(8'h10, v);
    chk("unmapped", 24'h0, 24'(v));
    chk("boot external", 24'h1, 24'(boot_external_out));
    reg_wr(SEG_DIR_OFS, 16'h000f);
    chk("segment enable", 24'h0f, 24'(segment_port_oe_out));
    reg_wr(SEG_DIR_OFS, 16'h00ff);
    reg_wr(SYSTEM_CONFIG_OFS, 16'h0036);
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      adr[i] = {lfsr_r, 8'(i)};
      lfsr_r = lfsr_next(lfsr_r);
      dat[i] = lfsr_r;
      access(1'b1, 1'b0, adr[i], dat[i], 2'h3);
      chk("segment lines", 24'(adr[i][23:16]), 24'(seg_cap));
    end
    for (int i = 0; i < 6; i++) begin
      access(1'b0, i[0], adr[i], 16'h0000, 2'h3);
      chk("read data", 24'(dat[i]), 24'(rd_cap));
    end
    reg_wr(SYSTEM_CONFIG_OFS, 16'h003e);
    wait_m <= 4'h4;
    access(1'b0, 1'b0, adr[2], 16'h0000, 2'h3);
    chk("wait data", 24'(dat[2]), 24'(rd_cap));
    chk("wait length", 24'h1, 24'(low_cnt > 4));
    wait_m <= 4'h0;
    reg_wr(SYSTEM_CONFIG_OFS, 16'h0037);
    for (int b = 1; b < 4; b++) access(1'b1, 1'b0, 24'h000010, 16'h1234, 2'(b));
    reg_wr(SYSTEM_CONFIG_OFS, 16'h0033);
    access(1'b1, 1'b0, 24'h000011, 16'hbeef, 2'h1);
    access(1'b0, 1'b0, 24'h000011, 16'h0000, 2'h1);
    chk("byte read", 24'h0000ef, 24'(rd_cap));
    reg_wr(SYSTEM_CONFIG_OFS, 16'h0034);
    access(1'b1, 1'b0, 24'h00a512, 16'h7e81, 2'h3);
    chk("demux address", 24'h00a512, 24'(dmx_cap));
    access(1'b0, 1'b0, 24'h00a512, 16'h0000, 2'h3);
    chk("demux data", 24'h007e81, 24'(rd_cap));
    reg_wr(SYSTEM_CONFIG_OFS, 16'h0036);
    chk("address enable", 24'h00ffff, 24'(demux_address_port_oe_out));
    resetn_in <= 1'b0;
    access_select_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    chk("boot internal", 24'h0, 24'(boot_external_out));
    complete_run();
  end
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule
